//--- vpc_pkg.sv
// Constants, register map and reset values for the valve position loop
package vpc_pkg;

   // ***************************************************************
   // Register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_GAIN_MAX = 8'h04;
   localparam logic [7:0] OFS_GAIN_MIN = 8'h08;
   localparam logic [7:0] OFS_GAIN_MULT = 8'h0c;
   localparam logic [7:0] OFS_IGAIN = 8'h10;
   localparam logic [7:0] OFS_NULL_BIAS = 8'h14;
   localparam logic [7:0] OFS_SHUT_LO = 8'h18;
   localparam logic [7:0] OFS_SOFT_LO = 8'h1c;
   localparam logic [7:0] OFS_SOFT_HI = 8'h20;
   localparam logic [7:0] OFS_DEADBAND = 8'h24;
   localparam logic [7:0] OFS_STROKE = 8'h28;
   localparam logic [7:0] OFS_TRAVEL = 8'h2c;
   localparam logic [7:0] OFS_STATUS = 8'h30;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
   localparam logic [7:0] OFS_INTEG = 8'h3c;
   localparam logic [7:0] OFS_DRIVE = 8'h40;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CTRL_RESTORE_BIT = 0;
   localparam int CTRL_SOFT_LO_EN_BIT = 1;
   localparam int CTRL_SOFT_HI_EN_BIT = 2;
   localparam int CTRL_SHUT_EN_BIT = 3;
   localparam int IRQ_SHUT_BIT = 0;
   localparam int IRQ_LIMIT_BIT = 1;
   localparam int IRQ_ICLAMP_BIT = 2;
   localparam int IRQ_TRAVEL_BIT = 3;
   localparam int IRQ_W = 4;

   // ***************************************************************
   // Reset and factory values, percent and gain limits in Q8.8, multiplier in Q0.16
   // ***************************************************************
   localparam logic [15:0] RST_GAIN_MAX = 16'h0200;
   localparam logic [15:0] RST_GAIN_MIN = 16'h0100;
   localparam logic [15:0] RST_GAIN_MULT = 16'h0ccd;
   localparam logic [15:0] RST_IGAIN = 16'h000a;
   localparam logic [15:0] RST_NULL_BIAS = 16'h0000;
   localparam logic [15:0] RST_SHUT_LO = 16'h0000;
   localparam logic [15:0] RST_SOFT_LO = 16'h0000;
   localparam logic [15:0] RST_SOFT_HI = 16'h6400;
   localparam logic [15:0] RST_DEADBAND = 16'h1400;
   localparam logic [15:0] RST_STROKE = 16'h0100;
   localparam logic [3:0] RST_CTRL = 4'h0;

   // ***************************************************************
   // Loop constants
   // ***************************************************************
   localparam logic signed [15:0] PCT_INTEG_LO = 16'sh0300;
   localparam logic signed [15:0] PCT_INTEG_HI = 16'sh6100;
   localparam logic signed [15:0] INTEG_LIM = 16'sh1400;
   localparam logic signed [15:0] SHUT_HYST = 16'sh0100;
   localparam logic signed [15:0] DRIVE_CLOSE = 16'sh8000;
   localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
   localparam logic signed [15:0] SAT_MIN = 16'sh8000;
   localparam int INTEG_SHIFT = 12;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int BLINK_HALF_NS = 250000000;
   localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

endpackage

//--- vpc_ctrl.sv
// Valve stem position PI loop with shutoff, soft limits and travel total
//
// How it works
// R01: gain is max minus deviation times multiplier
// R02: gain never below configured minimum gain
// R03: factory restore loads 2.0, 1.0, 0.05
// R04: integral gain defaults to ten
// R05: integrator frozen below 3 or above 97
// R06: integrator clamped to plus minus 20 percent
// R07: zero integral gain clears the integrator
// R08: drive is P plus integrator plus bias
// R09: calibration or host may load bias
// R10: command at threshold forces full close drive
// R11: leave shutoff at threshold plus 1 percent
// R12: shutoff only when lower limit at most zero
// R13: any soft stop disables the shutoff
// R14: hold at soft limit and blink yellow
// R15: deadband centred on position at power up
// R16: add scaled move, then recentre the deadband
// R17: deadband defaults to 20 percent
// R18: signed Q8.8 values with wide intermediates
// R19: shutoff state kept in a flip-flop
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module vpc_ctrl #(
   parameter int BLINK_HALF_CYC = vpc_pkg::BLINK_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic [31:0] hrdata_o,
   output logic hresp_o,
   input wire logic signed [15:0] cmd_i,
   input wire logic signed [15:0] stem_pos_i,
   input wire logic cal_bias_valid_i,
   input wire logic signed [15:0] cal_bias_i,
   output logic signed [15:0] spool_drive_o,
   output logic tight_shutoff_o,
   output logic yellow_led_o,
   output logic irq_o
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic dph_r, ready_r, wr_r, hit_r;
   logic [7:0] addr_r;
   logic [31:0] rdata_r, rd_mux;
   logic wr_en, restore;
   logic [3:0] ctrl_r;
   logic [15:0] gain_max_r, gain_min_r, gain_mult_r, igain_r;
   logic [15:0] deadband_r, stroke_r;
   logic signed [15:0] spool_null_bias_r, tight_shutoff_low_threshold_r;
   logic signed [15:0] lower_soft_limit_r, upper_soft_limit_r;
   logic signed [15:0] integ_r, drive_r, center_r;
   logic shut_r, lim_lo_r, lim_hi_r, iclamp_r, db_init_r, led_r, irq_r;
   logic [31:0] travel_r, blink_cnt_r;
   localparam int IRQ_W_L = vpc_pkg::IRQ_W;
   logic [IRQ_W_L-1:0] irq_st_r, irq_mk_r, ev;
   // Datapath
   logic signed [15:0] cmd_lim, p_term, integ_nxt;
   logic lim_lo, lim_hi, fn_act, shut_nxt, iclamp, db_out;
   logic signed [16:0] dev, move;
   logic [16:0] absdev, absmove;
   logic [32:0] red_prod, mv_prod;
   logic signed [17:0] kp_raw, db_hi, db_lo, shut_exit;
   logic [15:0] kp;
   logic signed [33:0] p_prod, i_prod, i_inc;
   logic signed [35:0] integ_sum, drive_sum;

   function automatic logic signed [35:0] ext16(input logic signed [15:0] v);
      ext16 = {{20{v[15]}}, v};
   endfunction

   function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
      logic signed [15:0] r;
      r = v[15:0];
      if (v > ext16(vpc_pkg::SAT_MAX)) begin
         r = vpc_pkg::SAT_MAX;
      end else if (v < ext16(vpc_pkg::SAT_MIN)) begin
         r = vpc_pkg::SAT_MIN;
      end
      sat16 = r;
   endfunction

   // ***************************************************************
   // AHB-Lite slave, one wait state per transfer
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dph_r <= 1'b0;
         ready_r <= 1'b1;
         wr_r <= 1'b0;
         hit_r <= 1'b0;
         addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else if (ce_i) begin
         if (dph_r) begin
            dph_r <= 1'b0;
            ready_r <= 1'b1;
            if (!wr_r) begin
               rdata_r <= rd_mux;
            end
         end else if (hsel_i && htrans_i[1] && hready_i) begin
            dph_r <= 1'b1;
            ready_r <= 1'b0;
            wr_r <= hwrite_i;
            hit_r <= (haddr_i[31:8] == 24'h00_0000) && (haddr_i[1:0] == 2'b00);
            addr_r <= haddr_i[7:0];
         end
      end
   end

   assign wr_en = ce_i && dph_r && wr_r && hit_r;
   assign restore = wr_en && (addr_r == vpc_pkg::OFS_CTRL) &&
                    hwdata_i[vpc_pkg::CTRL_RESTORE_BIT];

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_r) begin
         unique case (addr_r)
            vpc_pkg::OFS_CTRL: rd_mux = {28'h000_0000, ctrl_r};
            vpc_pkg::OFS_GAIN_MAX: rd_mux = {16'h0000, gain_max_r};
            vpc_pkg::OFS_GAIN_MIN: rd_mux = {16'h0000, gain_min_r};
            vpc_pkg::OFS_GAIN_MULT: rd_mux = {16'h0000, gain_mult_r};
            vpc_pkg::OFS_IGAIN: rd_mux = {16'h0000, igain_r};
            vpc_pkg::OFS_NULL_BIAS: rd_mux = {16'h0000, spool_null_bias_r};
            vpc_pkg::OFS_SHUT_LO: rd_mux = {16'h0000, tight_shutoff_low_threshold_r};
            vpc_pkg::OFS_SOFT_LO: rd_mux = {16'h0000, lower_soft_limit_r};
            vpc_pkg::OFS_SOFT_HI: rd_mux = {16'h0000, upper_soft_limit_r};
            vpc_pkg::OFS_DEADBAND: rd_mux = {16'h0000, deadband_r};
            vpc_pkg::OFS_STROKE: rd_mux = {16'h0000, stroke_r};
            vpc_pkg::OFS_TRAVEL: rd_mux = travel_r;
            vpc_pkg::OFS_STATUS: rd_mux = {28'h000_0000, iclamp_r, lim_hi_r, lim_lo_r, shut_r};
            vpc_pkg::OFS_IRQ_STAT: rd_mux = {28'h000_0000, irq_st_r};
            vpc_pkg::OFS_IRQ_MASK: rd_mux = {28'h000_0000, irq_mk_r};
            vpc_pkg::OFS_INTEG: rd_mux = {16'h0000, integ_r};
            vpc_pkg::OFS_DRIVE: rd_mux = {16'h0000, drive_r};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_r <= vpc_pkg::RST_CTRL;
         gain_max_r <= vpc_pkg::RST_GAIN_MAX;
         gain_min_r <= vpc_pkg::RST_GAIN_MIN;
         gain_mult_r <= vpc_pkg::RST_GAIN_MULT;
         igain_r <= vpc_pkg::RST_IGAIN;
         tight_shutoff_low_threshold_r <= vpc_pkg::RST_SHUT_LO;
         lower_soft_limit_r <= vpc_pkg::RST_SOFT_LO;
         upper_soft_limit_r <= vpc_pkg::RST_SOFT_HI;
         deadband_r <= vpc_pkg::RST_DEADBAND;
         stroke_r <= vpc_pkg::RST_STROKE;
         irq_mk_r <= '0;
      end else if (restore) begin
         // R03: factory gain set
         gain_max_r <= vpc_pkg::RST_GAIN_MAX;
         gain_min_r <= vpc_pkg::RST_GAIN_MIN;
         gain_mult_r <= vpc_pkg::RST_GAIN_MULT;
         // R04: integral gain default
         igain_r <= vpc_pkg::RST_IGAIN;
         ctrl_r <= {hwdata_i[3:1], 1'b0};
      end else if (wr_en) begin
         unique case (addr_r)
            vpc_pkg::OFS_CTRL: ctrl_r <= {hwdata_i[3:1], 1'b0};
            vpc_pkg::OFS_GAIN_MAX: gain_max_r <= hwdata_i[15:0];
            vpc_pkg::OFS_GAIN_MIN: gain_min_r <= hwdata_i[15:0];
            vpc_pkg::OFS_GAIN_MULT: gain_mult_r <= hwdata_i[15:0];
            vpc_pkg::OFS_IGAIN: igain_r <= hwdata_i[15:0];
            vpc_pkg::OFS_SHUT_LO: tight_shutoff_low_threshold_r <= hwdata_i[15:0];
            vpc_pkg::OFS_SOFT_LO: lower_soft_limit_r <= hwdata_i[15:0];
            vpc_pkg::OFS_SOFT_HI: upper_soft_limit_r <= hwdata_i[15:0];
            // R17: deadband writable, default 20 percent
            vpc_pkg::OFS_DEADBAND: deadband_r <= hwdata_i[15:0];
            vpc_pkg::OFS_STROKE: stroke_r <= hwdata_i[15:0];
            vpc_pkg::OFS_IRQ_MASK: irq_mk_r <= hwdata_i[IRQ_W_L-1:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   // R09: calibration load wins over host write
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         spool_null_bias_r <= vpc_pkg::RST_NULL_BIAS;
      end else if (ce_i && cal_bias_valid_i) begin
         spool_null_bias_r <= cal_bias_i;
      end else if (wr_en && addr_r == vpc_pkg::OFS_NULL_BIAS) begin
         spool_null_bias_r <= hwdata_i[15:0];
      end
   end

   // ***************************************************************
   // Control law datapath
   // ***************************************************************
   always_comb begin
      // R14: clamp command at soft limits
      lim_lo = ctrl_r[vpc_pkg::CTRL_SOFT_LO_EN_BIT] && (cmd_i < lower_soft_limit_r);
      lim_hi = ctrl_r[vpc_pkg::CTRL_SOFT_HI_EN_BIT] && (cmd_i > upper_soft_limit_r);
      cmd_lim = lim_lo ? lower_soft_limit_r : (lim_hi ? upper_soft_limit_r : cmd_i);
      // R18: 17 bit deviation, 33 bit unsigned and 34 bit signed products
      dev = 17'(cmd_lim) - 17'(stem_pos_i);
      absdev = dev[16] ? 17'(-dev) : 17'(dev);
      // R01: adaptive proportional gain
      red_prod = absdev * gain_mult_r;
      kp_raw = $signed({2'b00, gain_max_r}) - $signed({1'b0, red_prod[32:16]});
      // R02: floor at minimum gain
      kp = (kp_raw < $signed({2'b00, gain_min_r})) ? gain_min_r : kp_raw[15:0];
      p_prod = $signed({1'b0, kp}) * dev;
      p_term = sat16({{2{p_prod[33]}}, p_prod >>> 8});
      i_prod = $signed({1'b0, igain_r}) * dev;
      i_inc = i_prod >>> vpc_pkg::INTEG_SHIFT;
      integ_sum = ext16(integ_r) + {{2{i_inc[33]}}, i_inc};
      // R06: integrator clamp
      iclamp = 1'b0;
      integ_nxt = integ_sum[15:0];
      if (integ_sum > ext16(vpc_pkg::INTEG_LIM)) begin
         integ_nxt = vpc_pkg::INTEG_LIM;
         iclamp = 1'b1;
      end else if (integ_sum < -ext16(vpc_pkg::INTEG_LIM)) begin
         integ_nxt = -vpc_pkg::INTEG_LIM;
         iclamp = 1'b1;
      end
      // R08: sum of three control numbers
      drive_sum = ext16(p_term) + ext16(integ_r) + ext16(spool_null_bias_r);
      // R12: low cutoff needs lower limit at most zero
      // R13: disabled by either soft stop
      fn_act = ctrl_r[vpc_pkg::CTRL_SHUT_EN_BIT] &&
               !ctrl_r[vpc_pkg::CTRL_SOFT_LO_EN_BIT] &&
               !ctrl_r[vpc_pkg::CTRL_SOFT_HI_EN_BIT] &&
               (lower_soft_limit_r <= 16'sh0000);
      shut_exit = 18'(tight_shutoff_low_threshold_r) + 18'(vpc_pkg::SHUT_HYST);
      // R10: enter at or below threshold
      // R11: exit at threshold plus hysteresis
      shut_nxt = fn_act && (shut_r ? (18'(cmd_i) < shut_exit) :
                                     (cmd_i <= tight_shutoff_low_threshold_r));
      // R16: deadband window around centre
      db_hi = 18'(center_r) + $signed({2'b00, deadband_r});
      db_lo = 18'(center_r) - $signed({2'b00, deadband_r});
      db_out = (18'(stem_pos_i) > db_hi) || (18'(stem_pos_i) < db_lo);
      move = 17'(stem_pos_i) - 17'(center_r);
      absmove = move[16] ? 17'(-move) : 17'(move);
      mv_prod = absmove * stroke_r;
   end

   // ***************************************************************
   // Loop state
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         integ_r <= 16'sh0000;
         iclamp_r <= 1'b0;
      end else if (ce_i) begin
         // R07: zero gain clears summer
         if (igain_r == 16'h0000) begin
            integ_r <= 16'sh0000;
            iclamp_r <= 1'b0;
         // R05: freeze near the travel ends
         end else if (stem_pos_i >= vpc_pkg::PCT_INTEG_LO &&
                      stem_pos_i <= vpc_pkg::PCT_INTEG_HI) begin
            integ_r <= integ_nxt;
            iclamp_r <= iclamp;
         end
      end
   end

   // R19: registered shutoff state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         shut_r <= 1'b0;
         drive_r <= 16'sh0000;
         lim_lo_r <= 1'b0;
         lim_hi_r <= 1'b0;
      end else if (ce_i) begin
         shut_r <= shut_nxt;
         // R10: full close saturation
         drive_r <= shut_nxt ? vpc_pkg::DRIVE_CLOSE : sat16(drive_sum);
         lim_lo_r <= lim_lo;
         lim_hi_r <= lim_hi;
      end
   end

   // R14: yellow blink while limited
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         blink_cnt_r <= 32'h0000_0000;
         led_r <= 1'b0;
      end else if (ce_i) begin
         if (!(lim_lo || lim_hi)) begin
            blink_cnt_r <= 32'h0000_0000;
            led_r <= 1'b0;
         end else if (blink_cnt_r >= 32'(BLINK_HALF_CYC - 1)) begin
            blink_cnt_r <= 32'h0000_0000;
            led_r <= !led_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
         end
      end
   end

   // ***************************************************************
   // Travel accumulator
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         db_init_r <= 1'b0;
         center_r <= 16'sh0000;
         travel_r <= 32'h0000_0000;
      end else if (ce_i) begin
         if (!db_init_r) begin
            // R15: centre on power-up position
            db_init_r <= 1'b1;
            center_r <= stem_pos_i;
         end else if (db_out) begin
            // R16: accumulate and recentre
            travel_r <= travel_r + {7'h00, mv_prod[32:8]};
            center_r <= stem_pos_i;
         end
      end
   end

   // ***************************************************************
   // Interrupts
   // ***************************************************************
   always_comb begin
      ev = '0;
      ev[vpc_pkg::IRQ_SHUT_BIT] = ce_i && shut_nxt && !shut_r;
      ev[vpc_pkg::IRQ_LIMIT_BIT] = ce_i && (lim_lo || lim_hi) && !(lim_lo_r || lim_hi_r);
      ev[vpc_pkg::IRQ_ICLAMP_BIT] = ce_i && iclamp && !iclamp_r;
      ev[vpc_pkg::IRQ_TRAVEL_BIT] = ce_i && db_init_r && db_out;
   end

   for (genvar g = 0; g < IRQ_W_L; g++) begin : g_irq
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            irq_st_r[g] <= 1'b0;
         end else if (ev[g]) begin
            irq_st_r[g] <= 1'b1;
         end else if (wr_en && addr_r == vpc_pkg::OFS_IRQ_STAT && hwdata_i[g]) begin
            irq_st_r[g] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_r <= 1'b0;
      end else if (ce_i) begin
         irq_r <= |(irq_st_r & irq_mk_r);
      end
   end

   assign hreadyout_o = ready_r;
   assign hrdata_o = rdata_r;
   assign hresp_o = 1'b0;
   assign spool_drive_o = drive_r;
   assign tight_shutoff_o = shut_r;
   assign yellow_led_o = led_r;
   assign irq_o = irq_r;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   shutoff_drive_a: assert property (  // R10
      @(posedge clk_i) disable iff (sys_rst_i)
      shut_r |-> drive_r == vpc_pkg::DRIVE_CLOSE)
      else $error("drive not at full close in shutoff");

   shutoff_hold_a: assert property (  // R11
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && shut_r && fn_act && (18'(cmd_i) < shut_exit) |=> shut_r)
      else $error("shutoff left below exit threshold");

   shutoff_gate_a: assert property (  // R13
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && (ctrl_r[1] || ctrl_r[2] || lower_soft_limit_r > 16'sh0000) |=> !shut_r)
      else $error("shutoff active while gated off");

   integ_clamp_a: assert property (  // R06
      @(posedge clk_i) disable iff (sys_rst_i)
      integ_r <= vpc_pkg::INTEG_LIM && integ_r >= -vpc_pkg::INTEG_LIM)
      else $error("integrator beyond clamp");

   integ_hold_a: assert property (  // R05
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && igain_r != 16'h0000 && stem_pos_i < vpc_pkg::PCT_INTEG_LO |=> $stable(integ_r))
      else $error("integrator moved near closed end");

   integ_clear_a: assert property (  // R07
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && igain_r == 16'h0000 |=> integ_r == 16'sh0000)
      else $error("integrator not cleared");

   gain_floor_a: assert property (  // R02
      @(posedge clk_i) disable iff (sys_rst_i)
      kp >= gain_min_r)
      else $error("gain below minimum");

   restore_gain_a: assert property (  // R03
      @(posedge clk_i) disable iff (sys_rst_i)
      restore |=> gain_max_r == 16'h0200 && gain_min_r == 16'h0100 && igain_r == 16'h000a)
      else $error("factory restore values wrong");

   soft_limit_a: assert property (  // R14
      @(posedge clk_i) disable iff (sys_rst_i)
      ctrl_r[1] && cmd_i < lower_soft_limit_r |-> cmd_lim == lower_soft_limit_r)
      else $error("command passed lower soft limit");

   travel_recentre_a: assert property (  // R16
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && db_init_r && db_out |=> center_r == $past(stem_pos_i))
      else $error("deadband not recentred");

endmodule // vpc_ctrl

//--- vpc_stem_model.sv
// Stem and spool actuator model facing the position loop
`timescale 1ns/1ps
module vpc_stem_model (
   input wire logic clk_i,
   input wire logic signed [15:0] drive_i,
   input wire logic signed [15:0] target_i,
   output logic signed [15:0] stem_pos_o
);
   // Stiff stem: seats closed on full close drive, else settles on target
   always_ff @(posedge clk_i) begin
      if (drive_i == 16'sh8000) begin
         stem_pos_o <= 16'sh0000;
      end else begin
         stem_pos_o <= target_i;
      end
   end
endmodule // vpc_stem_model

//--- tb.sv
// Self-checking bench for the valve position loop
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic hresp;
   logic [31:0] hrdata;
   logic signed [15:0] cmd = 16'sh3200;
   logic signed [15:0] pos_set = 16'sh3200;
   logic signed [15:0] stem_pos;
   logic cal_v = 1'b0;
   logic signed [15:0] cal_b = 16'sh0000;
   logic signed [15:0] drive;
   logic shut;
   logic led;
   logic irq;
   logic led_old;
   logic [31:0] rd;
   int n_fail = 0;
   int check_count = 0;
   always #2.5 clk = ~clk;
   vpc_ctrl #(.BLINK_HALF_CYC(4)) vpc_ctrl_inst (.clk_i(clk), .sys_rst_i(rst), .ce_i(ce),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
      .hrdata_o(hrdata), .hresp_o(hresp), .cmd_i(cmd), .stem_pos_i(stem_pos),
      .cal_bias_valid_i(cal_v), .cal_bias_i(cal_b), .spool_drive_o(drive),
      .tight_shutoff_o(shut), .yellow_led_o(led), .irq_o(irq));
   vpc_stem_model vpc_stem_model_inst (.clk_i(clk), .drive_i(drive), .target_i(pos_set),
      .stem_pos_o(stem_pos));
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One AHB-Lite single word transfer, waits on hready in both phases
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, rd, e);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic gains;
      rchk("gain_max", vpc_pkg::OFS_GAIN_MAX, 32'h0000_0200);
      rchk("gain_min", vpc_pkg::OFS_GAIN_MIN, 32'h0000_0100);
      rchk("gain_mult", vpc_pkg::OFS_GAIN_MULT, 32'h0000_0ccd);
      rchk("igain", vpc_pkg::OFS_IGAIN, 32'h0000_000a);
   endtask
   initial begin
      #20000;
      n_fail++;
      final_report;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      ticks(2);
      pos_set <= 16'sh5000;
      ticks(4);
      rchk("travel", vpc_pkg::OFS_TRAVEL, 32'h0000_1e00);
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
      gains();
      rchk("deadband", vpc_pkg::OFS_DEADBAND, 32'h0000_1400);
      rchk("unmapped", 8'h80, 32'h0000_0000);
      $display("test reset_values done");
      wr(vpc_pkg::OFS_IGAIN, 32'h0000_0000);
      ticks(2);
      rchk("integ_clear", vpc_pkg::OFS_INTEG, 32'h0000_0000);
      pos_set <= 16'sh0200;
      wr(vpc_pkg::OFS_IGAIN, 32'h0000_0100);
      ticks(20);
      rchk("integ_frozen", vpc_pkg::OFS_INTEG, 32'h0000_0000);
      pos_set <= 16'sh3200;
      cmd <= 16'sh4200;
      ticks(40);
      rchk("integ_clamp", vpc_pkg::OFS_INTEG, 32'h0000_1400);
      $display("test integrator done");
      wr(vpc_pkg::OFS_IGAIN, 32'h0000_0000);
      wr(vpc_pkg::OFS_GAIN_MULT, 32'h0000_8000);
      wr(vpc_pkg::OFS_NULL_BIAS, 32'h0000_0100);
      @(posedge clk);
      cal_v <= 1'b1;
      cal_b <= 16'sh0200;
      @(posedge clk);
      cal_v <= 1'b0;
      rchk("bias", vpc_pkg::OFS_NULL_BIAS, 32'h0000_0200);
      cmd <= 16'sh3300;
      ticks(4);
      chk("drive_adapt", {16'h0000, drive}, 32'h0000_0380);
      cmd <= 16'sh3600;
      ticks(4);
      chk("drive_min", {16'h0000, drive}, 32'h0000_0600);
      ce <= 1'b0;
      cmd <= 16'sh3300;
      ticks(3);
      chk("ce_freeze", {16'h0000, drive}, 32'h0000_0600);
      ce <= 1'b1;
      cmd <= 16'sh3600;
      wr(vpc_pkg::OFS_GAIN_MAX, 32'h0000_0300);
      wr(vpc_pkg::OFS_CTRL, 32'h0000_0001);
      gains();
      $display("test gains done");
      wr(vpc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      wr(vpc_pkg::OFS_SHUT_LO, 32'h0000_0500);
      wr(vpc_pkg::OFS_CTRL, 32'h0000_0008);
      cmd <= 16'sh0500;
      ticks(3);
      chk("shut_enter", {31'h0, shut}, 32'h0000_0001);
      chk("shut_drive", {16'h0000, drive}, 32'h0000_8000);
      chk("irq_set", {31'h0, irq}, 32'h0000_0001);
      cmd <= 16'sh05ff;
      ticks(3);
      chk("shut_hold", {31'h0, shut}, 32'h0000_0001);
      cmd <= 16'sh0600;
      ticks(3);
      chk("shut_leave", {31'h0, shut}, 32'h0000_0000);
      wr(vpc_pkg::OFS_IRQ_STAT, 32'h0000_000f);
      ticks(2);
      chk("irq_clear", {31'h0, irq}, 32'h0000_0000);
      wr(vpc_pkg::OFS_SOFT_LO, 32'h0000_0100);
      cmd <= 16'sh0400;
      ticks(3);
      chk("shut_lowlimit", {31'h0, shut}, 32'h0000_0000);
      wr(vpc_pkg::OFS_CTRL, 32'h0000_000a);
      wr(vpc_pkg::OFS_SOFT_LO, 32'h0000_0000);
      ticks(3);
      chk("shut_softstop", {31'h0, shut}, 32'h0000_0000);
      $display("test shutoff done");
      wr(vpc_pkg::OFS_SOFT_HI, 32'h0000_4000);
      wr(vpc_pkg::OFS_CTRL, 32'h0000_0004);
      cmd <= 16'sh5000;
      ticks(6);
      bus(1'b0, vpc_pkg::OFS_STATUS, 32'h0000_0000);
      chk("limit_hi", {31'h0, rd[2]}, 32'h0000_0001);
      led_old = led;
      ticks(4);
      chk("led_blink", {31'h0, led ^ led_old}, 32'h0000_0001);
      $display("test soft_limit done");
      final_report;
   end
endmodule // tb
